// >>> core/connector_mode_select.sv
// Power-up interface mode selection and pin qualification for the 68-pin connector.
// Assumes nrst_i is the power-on reset, released once supply is within tolerance.
`timescale 1ns/100ps
module connector_mode_select #(
    parameter int DEBOUNCE_CYCLES = mode_select_pkg::DEBOUNCE_CYCLES,
    parameter bit USE_CABLE_SELECT = 1'b1,
    parameter bit SUPPORT_DMA = 1'b1,
    parameter bit SUPPORT_READY = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic interface_mode_select_n_i,
    input wire logic chip_select_cmd_n_i,
    input wire logic chip_select_ctl_n_i,
    input wire logic chip_select_ctl_alt_n_i,
    input wire logic host_reset_i,
    input wire logic position_select_n_i,
    input wire logic cable_position_select_i,
    input wire logic dma_acknowledge_n_i,
    input wire logic [6:0] card_address_i,
    input wire logic card_write_enable_n_i,
    input wire logic core_dma_request_i,
    input wire logic core_ready_i,
    output logic presence_detect_a_n_o,
    output logic presence_detect_b_n_o,
    output logic voltage_sense_a_n_o,
    output logic voltage_sense_a_n_oe_o,
    output logic voltage_sense_b_n_o,
    output logic voltage_sense_b_n_oe_o,
    output logic dma_request_o,
    output logic channel_ready_o,
    output logic native_mode_o,
    output logic card_mode_o,
    output logic device_disabled_o,
    output mode_select_pkg::core_ctl_type core_ctl_o
);

    if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
        $error("DEBOUNCE_CYCLES must be at least one");
    end

    localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

    logic rst_meta;
    logic rst_sync_n;
    logic [CNT_W-1:0] debounce_count;
    logic debounce_done;
    mode_select_pkg::mode_state_type state;
    mode_select_pkg::mode_state_type next_state;
    mode_select_pkg::host_ctl_type host_ctl;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Counts from power-on only; nothing else restarts it.
    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            debounce_count <= '0;
            debounce_done <= 1'b0;
        end else if (!debounce_done) begin
            if (debounce_count == CNT_LAST) begin
                debounce_done <= 1'b1; // [RULE1]
            end else begin
                debounce_count <= debounce_count + 1'b1;
            end
        end
    end

    // The host reset input is not an input to this machine, so the mode
    // survives hard and soft resets and only a power cycle reopens it.
    always_comb begin
        next_state = state;
        case (state)
            mode_select_pkg::ST_WAIT: begin
                if (debounce_done) begin
                    if (!interface_mode_select_n_i) begin
                        next_state = mode_select_pkg::ST_NATIVE; // [RULE18]
                    end else begin
                        next_state = mode_select_pkg::ST_CARD; // [RULE2]
                    end
                end
            end
            mode_select_pkg::ST_NATIVE: begin
                if (interface_mode_select_n_i) begin
                    next_state = mode_select_pkg::ST_DISABLED; // [RULE14]
                end
            end
            mode_select_pkg::ST_CARD: next_state = mode_select_pkg::ST_CARD; // [RULE3]
            mode_select_pkg::ST_DISABLED: next_state = mode_select_pkg::ST_DISABLED;
            default: next_state = mode_select_pkg::ST_DISABLED;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= mode_select_pkg::ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Until native mode is settled every strobe but reset reads as negated, which
    // keeps a hot-inserted device from being selected falsely.
    always_comb begin
        host_ctl = '1; // [RULE15]
        // The core is kept in reset outside native mode, so a card host or a
        // disabled slot can never start it.
        host_ctl.reset_n = 1'b0; // [RULE13]
        host_ctl.position_select = 1'b0;
        if (state == mode_select_pkg::ST_NATIVE) begin
            host_ctl.chip_select_cmd_n = chip_select_cmd_n_i;
            // The alternate control select position is left unused.
            host_ctl.chip_select_ctl_n = chip_select_ctl_n_i; // [RULE7]
            // Native reset is active low; a card host drives it high in reset,
            // so a device left unconfigured there stays held in reset.
            host_ctl.reset_n = host_reset_i; // [RULE13]
            host_ctl.dma_acknowledge_n = SUPPORT_DMA ? dma_acknowledge_n_i : 1'b1; // [RULE10]
            host_ctl.position_select = USE_CABLE_SELECT ? cable_position_select_i
                                                        : !position_select_n_i; // [RULE8]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_ctl_o <= '0;
            core_ctl_o.device_reset <= 1'b1;
        end else begin
            core_ctl_o.chip_select_cmd <= !host_ctl.chip_select_cmd_n;
            core_ctl_o.chip_select_ctl <= !host_ctl.chip_select_ctl_n;
            core_ctl_o.device_reset <= !host_ctl.reset_n;
            core_ctl_o.dma_acknowledge <= !host_ctl.dma_acknowledge_n;
            core_ctl_o.is_secondary <= host_ctl.position_select;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dma_request_o <= 1'b0;
            channel_ready_o <= 1'b0;
        end else begin
            dma_request_o <= SUPPORT_DMA && state == mode_select_pkg::ST_NATIVE
                             && core_dma_request_i; // [RULE11] [RULE10]
            channel_ready_o <= SUPPORT_READY && state == mode_select_pkg::ST_NATIVE
                               && core_ready_i; // [RULE11]
        end
    end

    // Card-only address, write-enable and sense pins feed nothing here;
    // the sense pins are released so the device never drives them.
    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            presence_detect_a_n_o <= 1'b0;
            presence_detect_b_n_o <= 1'b0;
            voltage_sense_a_n_o <= 1'b0;
            voltage_sense_a_n_oe_o <= 1'b1;
            voltage_sense_b_n_o <= 1'b0;
            voltage_sense_b_n_oe_o <= 1'b1;
        end else begin
            presence_detect_a_n_o <= 1'b0; // [RULE5]
            presence_detect_b_n_o <= 1'b0; // [RULE5]
            voltage_sense_a_n_o <= 1'b0;
            voltage_sense_a_n_oe_o <= 1'b1; // [RULE12]
            voltage_sense_b_n_o <= 1'b0;
            voltage_sense_b_n_oe_o <= 1'b1; // [RULE12]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            native_mode_o <= 1'b0;
            card_mode_o <= 1'b0;
            device_disabled_o <= 1'b0;
        end else begin
            native_mode_o <= next_state == mode_select_pkg::ST_NATIVE;
            card_mode_o <= next_state == mode_select_pkg::ST_CARD;
            device_disabled_o <= next_state == mode_select_pkg::ST_DISABLED;
        end
    end

endmodule : connector_mode_select

// >>> pkg/mode_select_pkg.sv
// Constants and signal groups for the connector mode selection block.
// Assumes a single 200 MHz clock and a power-on reset that marks supply in tolerance.
// Overview of operation
// RULE1 - Ignore all interface inputs for 19 msec.
// RULE2 - Strap negated after interval: card mode or silent.
// RULE3 - Never resample strap on hard/soft reset.
// RULE4 - Host asserts strap before power, holds it.
// RULE5 - Both presence detect outputs tied low.
// RULE6 - Host drives control select on both positions.
// RULE7 - Use only one control select position.
// RULE8 - Implement position select or cable select, one.
// RULE9 - Host provides both selects before power.
// RULE10 - DMA request and acknowledge implemented together.
// RULE11 - Unsupported ready or DMA request held negated.
// RULE12 - Native mode ignores card-only inputs.
// RULE13 - Reset polarity differs between host modes.
// RULE14 - Strap negated later in native: disable until off.
// RULE15 - Selects, reset, strap negated internally for hot insertion; reset is held asserted outside native mode here.
// RULE16 - Host resets devices on insertion or removal.
// RULE17 - Host detects insertion to protect commands.
// RULE18 - Latch mode at interval end until power off.
package mode_select_pkg;

    localparam int CLK_FREQ_KHZ = 200000;
    localparam int DEBOUNCE_MS = 19;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_FREQ_KHZ;

    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_NATIVE = 4'h2,
        ST_CARD = 4'h4,
        ST_DISABLED = 4'h8
    } mode_state_type;

    // Host-side control strobes as seen at the connector, all active low except position select.
    typedef struct packed {
        logic chip_select_cmd_n;
        logic chip_select_ctl_n;
        logic reset_n;
        logic dma_acknowledge_n;
        logic position_select;
    } host_ctl_type;

    // Qualified controls handed to the protocol core, all active high.
    typedef struct packed {
        logic chip_select_cmd;
        logic chip_select_ctl;
        logic device_reset;
        logic dma_acknowledge;
        logic is_secondary;
    } core_ctl_type;

endpackage : mode_select_pkg

// >>> verification/connector_mode_select_chk.sv
// Port-level checker for the connector mode selection block.
// Bound from the bench; sees only the top module's ports.
`timescale 1ns/100ps
module connector_mode_select_chk #(
    parameter int DEBOUNCE_CYCLES = 16
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic interface_mode_select_n_i,
    input wire logic chip_select_cmd_n_i,
    input wire logic chip_select_ctl_n_i,
    input wire logic host_reset_i,
    input wire logic core_dma_request_i,
    input wire logic presence_detect_a_n_o,
    input wire logic presence_detect_b_n_o,
    input wire logic voltage_sense_a_n_oe_o,
    input wire logic dma_request_o,
    input wire logic channel_ready_o,
    input wire logic native_mode_o,
    input wire logic card_mode_o,
    input wire logic device_disabled_o,
    input wire mode_select_pkg::core_ctl_type core_ctl_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    int wait_cnt;
    wire mode_any = native_mode_o | card_mode_o | device_disabled_o;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_cnt <= 0;
        end else if (!mode_any) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    sequence s_quiet; !native_mode_o && !$past(native_mode_o); endsequence
    sequence s_steady; native_mode_o && $past(native_mode_o); endsequence
    sequence s_strap_drop; native_mode_o && interface_mode_select_n_i; endsequence
    a_presence_grounded: assert property (!presence_detect_a_n_o && !presence_detect_b_n_o)
        else $error("presence detect not low");
    a_sense_released: assert property (voltage_sense_a_n_oe_o)
        else $error("voltage sense pin driven");
    a_quiet_outside: assert property (s_quiet |-> core_ctl_o == 5'h04 && !dma_request_o
        && !channel_ready_o) else $error("host strobes not negated");
    a_selects_follow: assert property (s_steady |-> core_ctl_o.chip_select_cmd ==
        !$past(chip_select_cmd_n_i) && core_ctl_o.chip_select_ctl == !$past(chip_select_ctl_n_i))
        else $error("chip selects not passed");
    a_reset_follows: assert property (s_steady |-> core_ctl_o.device_reset ==
        !$past(host_reset_i)) else $error("reset polarity wrong");
    a_dma_follows: assert property (s_steady |-> dma_request_o ==
        $past(core_dma_request_i)) else $error("dma request not passed");
    a_mode_onehot: assert property ($onehot0({native_mode_o, card_mode_o, device_disabled_o}))
        else $error("mode outputs not one-hot");
    a_mode_sticky: assert property (card_mode_o || device_disabled_o |=>
        $stable({card_mode_o, device_disabled_o})) else $error("mode changed");
    a_strap_drop: assert property (s_strap_drop |-> ##[1:2] device_disabled_o)
        else $error("not disabled after strap loss");
    a_debounce_hold: assert property (mode_any |-> wait_cnt >= DEBOUNCE_CYCLES)
        else $error("mode chosen too early");
    a_debounce_bound: assert property (wait_cnt < DEBOUNCE_CYCLES + 6)
        else $error("mode never chosen");
endmodule : connector_mode_select_chk

// >>> verification/host_adapter_model.sv
// Host adapter model: turns active-high bench requests into connector pins.
// Combinational, so the bench's falling-edge timing reaches the pins as is.
`timescale 1ns/100ps
module host_adapter_model (
    input wire logic native_i,
    input wire logic [4:0] req_i,
    input wire logic alt_bad_i,
    output logic strap_n_o,
    output logic cmd_n_o,
    output logic ctl_n_o,
    output logic ctl_alt_n_o,
    output logic reset_pin_o,
    output logic dack_n_o,
    output logic pos_n_o,
    output logic cable_position_select_o
);
    assign strap_n_o = !native_i;
    assign cmd_n_o = !req_i[4];
    assign ctl_n_o = !req_i[3];
    // The second position only disagrees when the bench asks, to probe which pin is used.
    assign ctl_alt_n_o = !req_i[3] ^ alt_bad_i;
    assign reset_pin_o = !req_i[2];
    assign dack_n_o = !req_i[1];
    assign pos_n_o = !req_i[0];
    assign cable_position_select_o = req_i[0];
endmodule : host_adapter_model

// >>> verification/connector_mode_select_tb.sv
// Self-checking bench for the connector mode selection block.
// Short debounce count; host pins come from the adapter model.
`timescale 1ns/100ps
module connector_mode_select_tb;
    localparam int DEBOUNCE_CYCLES = 16;
    logic clk = 0, nrst = 0, native = 1, alt_bad = 0, we_n = 1, dreq = 0, rdy = 0;
    logic [4:0] req = 5'h00;
    logic [6:0] addr = 7'h00;
    logic [31:0] rng = 32'h0000216d;
    logic strap_n, cmd_n, ctl_n, alt_n, rst_pin, dack_n, pos_n, cable_position_select;
    logic pd_a, pd_b, dma_o, rdy_o, nat, card, dis;
    mode_select_pkg::core_ctl_type ctl_o;
    int err_total = 0, checks_done = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    host_adapter_model u_host (.native_i(native), .req_i(req), .alt_bad_i(alt_bad),
        .strap_n_o(strap_n), .cmd_n_o(cmd_n), .ctl_n_o(ctl_n), .ctl_alt_n_o(alt_n),
        .reset_pin_o(rst_pin), .dack_n_o(dack_n), .pos_n_o(pos_n), .cable_position_select_o(cable_position_select));
    connector_mode_select #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_dut (.sys_clk_i(clk),
        .nrst_i(nrst), .interface_mode_select_n_i(strap_n), .chip_select_cmd_n_i(cmd_n),
        .chip_select_ctl_n_i(ctl_n), .chip_select_ctl_alt_n_i(alt_n), .host_reset_i(rst_pin),
        .position_select_n_i(pos_n), .cable_position_select_i(cable_position_select), .dma_acknowledge_n_i(dack_n),
        .card_address_i(addr), .card_write_enable_n_i(we_n), .core_dma_request_i(dreq),
        .core_ready_i(rdy), .presence_detect_a_n_o(pd_a), .presence_detect_b_n_o(pd_b),
        .voltage_sense_a_n_o(), .voltage_sense_a_n_oe_o(), .voltage_sense_b_n_o(),
        .voltage_sense_b_n_oe_o(), .dma_request_o(dma_o), .channel_ready_o(rdy_o),
        .native_mode_o(nat), .card_mode_o(card), .device_disabled_o(dis), .core_ctl_o(ctl_o));
    function automatic logic [31:0] next_rng(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rng
    function automatic logic [4:0] exp_ctl(input logic live, input logic [4:0] r);
        return live ? r : 5'h04;
    endfunction : exp_ctl
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out;
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic drive_random;
        rng = next_rng(rng);
        {rdy, dreq, we_n, addr, alt_bad, req} = rng[15:0];
    endtask : drive_random
    // Power is modelled by the reset input, with the strap set while it is low.
    task automatic power_up(input logic mode);
        int n;
        nrst = 0;
        native = mode;
        repeat (12) @(negedge clk);
        nrst = 1;
        n = 0;
        while (!(nat | card | dis) && n < 60) begin
            drive_random();
            @(negedge clk);
            n++;
            if (!(nat | card | dis)) chk("core_ctl_wait", 8'h04, {3'h0, ctl_o});
        end
        chk("debounce", 8'h01, {7'h00, n > DEBOUNCE_CYCLES && n < DEBOUNCE_CYCLES + 6});
    endtask : power_up
    task automatic step(input logic [2:0] m);
        drive_random();
        @(negedge clk);
        chk("mode", {5'h00, m}, {5'h00, nat, card, dis});
        chk("core_ctl", {3'h0, exp_ctl(m[2], req)}, {3'h0, ctl_o});
        chk("dma_ready", {6'h00, dreq & m[2], rdy & m[2]}, {6'h00, dma_o, rdy_o});
        chk("presence", 8'h00, {6'h00, pd_a, pd_b});
    endtask : step
    initial begin
        power_up(1'b1);
        repeat (40) step(3'b100);
        native = 0;
        repeat (2) @(negedge clk);
        native = 1;
        repeat (8) step(3'b001);
        power_up(1'b0);
        native = 1;
        repeat (20) step(3'b010);
        power_up(1'b1);
        repeat (10) step(3'b100);
        close_out();
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : connector_mode_select_tb
bind connector_mode_select connector_mode_select_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.*);
